// File: common/atb_params.svh
`ifndef ATB_PARAMS_SVH
`define ATB_PARAMS_SVH
// ----------------------------------------
// Register addresses
// ----------------------------------------
`define ATB_ADDR_TEST_SIG   8'h02
`define ATB_ADDR_REF_BIAS   8'h03
`define ATB_ADDR_LEAD_OFF   8'h04
// ----------------------------------------
// Reset values
// ----------------------------------------
`define ATB_RST_TEST_SIG    8'hC0
`define ATB_RST_REF_BIAS    8'h60
`define ATB_RST_LEAD_OFF    8'h00
// ----------------------------------------
// Field positions
// ----------------------------------------
`define ATB_TS_INTERNAL_BIT 4
`define ATB_TS_AMP_BIT      2
`define ATB_RB_STATUS_BIT   0
`define ATB_LO_ZERO_BIT     4
// Rate divider exponents, in device clocks
`define ATB_RATE_EXP_SLOW   21
`define ATB_RATE_EXP_FAST   20
`endif

// File: common/atb_pkg.sv
package atb_pkg;
    // Test rate codes
    typedef enum logic [1:0] {
        ATB_RATE_SLOW   = 2'h0,
        ATB_RATE_FAST   = 2'h1,
        ATB_RATE_UNUSED = 2'h2,
        ATB_RATE_DC     = 2'h3
    } atb_rate_e;

    // Register access request
    typedef struct packed {
        logic       wr_en;
        logic [7:0] addr;
        logic [7:0] wdata;
    } atb_req_s;

    // Decoded controls toward the analog side
    typedef struct packed {
        logic       test_internal;
        logic       test_amplitude_double;
        logic       test_pulse;
        logic       test_dc;
        logic       reference_buffer_enable;
        logic       bias_measure_route;
        logic       bias_reference_internal;
        logic       bias_buffer_enable;
        logic       bias_sense_enable;
        logic [2:0] comparator_threshold;
        logic [1:0] lead_off_current_select;
        logic [1:0] lead_off_frequency_select;
    } atb_ctrl_s;
endpackage

// File: rtl/atb_config_regs.sv
`timescale 1ns/100ps
`include "atb_params.svh"
module atb_config_regs #(
    parameter int RATE_EXP_SLOW = `ATB_RATE_EXP_SLOW,
    parameter int RATE_EXP_FAST = `ATB_RATE_EXP_FAST
) (
    input  wire logic              mclk,
    input  wire logic              resetn,
    input  wire atb_pkg::atb_req_s req,
    input  wire logic              bias_lead_off,
    input  wire logic [2:0]        chan_mux_sel,
    output logic [7:0]             rdata,
    output atb_pkg::atb_ctrl_s     ctrl,
    output logic                   bias_route_hit
);
    import atb_pkg::*;

    // ----------------------------------------
    // Reset release
    // ----------------------------------------
    logic       rst_meta;
    logic       rst_sync_n;
    logic [7:0] test_signal_config;
    logic [7:0] reference_bias_config;
    logic [7:0] lead_off_control;
    logic [RATE_EXP_SLOW-1:0] rate_cnt;
    logic       bias_stat;
    logic       pulse_level;

    // Two stages so release is clean against mclk
    always_ff @(posedge mclk or negedge resetn) begin
        if (!resetn) begin
            rst_meta   <= 1'b0;
            rst_sync_n <= 1'b0;
        end else begin
            rst_meta   <= 1'b1;
            rst_sync_n <= rst_meta;
        end
    end

    // ----------------------------------------
    // Register storage
    // ----------------------------------------
    // Host is trusted to keep fixed bits; stored as written
    always_ff @(posedge mclk or negedge rst_sync_n) begin
        if (!rst_sync_n) begin
            test_signal_config <= `ATB_RST_TEST_SIG;
        end else if (req.wr_en && req.addr == `ATB_ADDR_TEST_SIG) begin
            test_signal_config <= req.wdata;
        end
    end

    // Status bit never stored from write data
    always_ff @(posedge mclk or negedge rst_sync_n) begin
        if (!rst_sync_n) begin
            reference_bias_config <= `ATB_RST_REF_BIAS;
        end else if (req.wr_en && req.addr == `ATB_ADDR_REF_BIAS) begin
            reference_bias_config <= {req.wdata[7:1], 1'b0};
        end
    end

    // Bit 4 forced to zero regardless of write data
    always_ff @(posedge mclk or negedge rst_sync_n) begin
        if (!rst_sync_n) begin
            lead_off_control <= `ATB_RST_LEAD_OFF;
        end else if (req.wr_en && req.addr == `ATB_ADDR_LEAD_OFF) begin
            lead_off_control <= {req.wdata[7:5], 1'b0,
                                 req.wdata[3:0]};
        end
    end

    // Lead-off status sampled each clock
    always_ff @(posedge mclk or negedge rst_sync_n) begin
        if (!rst_sync_n) begin
            bias_stat <= 1'b0;
        end else begin
            bias_stat <= bias_lead_off;
        end
    end

    // ----------------------------------------
    // Test rate divider
    // ----------------------------------------
    // Free-running; the pulse is a square wave at the slow or fast rate, high for DC, low for the unused code
    always_ff @(posedge mclk or negedge rst_sync_n) begin
        if (!rst_sync_n) begin
            rate_cnt <= '0;
        end else begin
            rate_cnt <= rate_cnt + 1'b1;
        end
    end

    // Square wave: top bit of a 2^N count toggles once per 2^(N-1)
    always_comb begin
        case (atb_rate_e'(test_signal_config[1:0]))
            ATB_RATE_SLOW: pulse_level = rate_cnt[RATE_EXP_SLOW-1];
            ATB_RATE_FAST: pulse_level = rate_cnt[RATE_EXP_FAST-1];
            ATB_RATE_DC:   pulse_level = 1'b1;
            default:       pulse_level = 1'b0; // Unused code held low
        endcase
    end

    // ----------------------------------------
    // Read path
    // ----------------------------------------
    function automatic logic [7:0] read_mux(input logic [7:0] a);
        case (a)
            `ATB_ADDR_TEST_SIG: read_mux = test_signal_config;
            `ATB_ADDR_REF_BIAS: read_mux = {reference_bias_config[7:1],
                                            bias_stat};
            `ATB_ADDR_LEAD_OFF: read_mux = lead_off_control;
            default:            read_mux = 8'h00;
        endcase
    endfunction

    // Registered read data, one cycle after address
    always_ff @(posedge mclk or negedge rst_sync_n) begin
        if (!rst_sync_n) begin
            rdata <= 8'h00;
        end else begin
            rdata <= read_mux(req.addr);
        end
    end

    // ----------------------------------------
    // Control outputs
    // ----------------------------------------
    // Registered so every output comes straight from a flop
    always_ff @(posedge mclk or negedge rst_sync_n) begin
        if (!rst_sync_n) begin
            ctrl           <= '0;
            bias_route_hit <= 1'b0;
        end else begin
            ctrl.test_internal <=
                test_signal_config[`ATB_TS_INTERNAL_BIT];
            ctrl.test_amplitude_double <=
                test_signal_config[`ATB_TS_AMP_BIT];
            ctrl.test_pulse <= pulse_level;
            ctrl.test_dc <=
                (test_signal_config[1:0] == ATB_RATE_DC);
            ctrl.reference_buffer_enable <=
                reference_bias_config[7];
            ctrl.bias_measure_route <= reference_bias_config[4];
            ctrl.bias_reference_internal <=
                reference_bias_config[3];
            ctrl.bias_buffer_enable <= reference_bias_config[2];
            ctrl.bias_sense_enable <= reference_bias_config[1];
            ctrl.comparator_threshold <= lead_off_control[7:5];
            ctrl.lead_off_current_select <= lead_off_control[3:2];
            ctrl.lead_off_frequency_select <= lead_off_control[1:0];
            // Path stays open unless enabled and mux selects 010
            bias_route_hit <= reference_bias_config[4] &&
                              (chan_mux_sel == 3'h2);
        end
    end
endmodule // atb_config_regs

// File: sim/atb_host_model.sv
`timescale 1ns/100ps
module atb_host_model (
    input  wire logic        mclk,
    output atb_pkg::atb_req_s req
);
    import atb_pkg::*;
    initial req = '0;
    // Reserved fields of registers 02 and 03 carry their required values; lead-off data is sent as given
    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        @(posedge mclk);
        req <= '{1'b1, a, a == 8'h02 ? {3'h6, d[4], 1'b0, d[2:0]} :
                 a == 8'h03 ? {d[7], 2'h3, d[4:0]} : d};
        @(posedge mclk);
        req.wr_en <= 1'b0;
    endtask
    // Read data lands one edge after the address
    task automatic rd(input logic [7:0] a);
        @(posedge mclk);
        req.addr <= a;
        @(posedge mclk);
        @(negedge mclk);
    endtask
endmodule // atb_host_model

// File: sim/atb_chk_sva.sv
`timescale 1ns/100ps
module atb_chk (
    input wire logic               mclk,
    input wire logic               resetn,
    input wire atb_pkg::atb_req_s  req,
    input wire logic               bias_lead_off,
    input wire logic [2:0]         chan_mux_sel,
    input wire logic [7:0]         rdata,
    input wire atb_pkg::atb_ctrl_s ctrl,
    input wire logic               bias_route_hit
);
    import atb_pkg::*;
    logic [2:0] age;
    wire        ok = age == 3'h7;
    default clocking @(posedge mclk); endclocking
    default disable iff (!resetn);
    // Skip the synchroniser latency after every reset
    always_ff @(posedge mclk or negedge resetn) begin
        if (!resetn) age <= 3'h0;
        else if (!ok) age <= age + 3'h1;
    end
    a_unmapped_zero: assert property (
        ok && !(req.addr inside {8'h02, 8'h03, 8'h04}) |=> rdata == 8'h00)
        else $error("unmapped read not zero");
    a_lead_off_echo: assert property (
        ok && req.wr_en && req.addr == 8'h04 ##1 req.addr == 8'h04 &&
        !req.wr_en |=> rdata == ($past(req.wdata, 2) & 8'hEF))
        else $error("lead-off readback wrong");
    a_status_ignored: assert property (
        ok && req.wr_en && req.addr == 8'h03 ##1 req.addr == 8'h03 &&
        !req.wr_en |=> rdata[7:1] == $past(req.wdata[7:1], 2))
        else $error("bias register readback wrong");
    a_status_follows: assert property (
        ok && req.addr == 8'h03 && $stable(bias_lead_off)
        |=> rdata[0] == $past(bias_lead_off))
        else $error("status bit wrong");
    a_test_ctrl: assert property (
        ok && req.wr_en && req.addr == 8'h02 ##1 !req.wr_en |=>
        {ctrl.test_internal, ctrl.test_amplitude_double} ==
        {$past(req.wdata[4], 2), $past(req.wdata[2], 2)})
        else $error("test controls wrong");
    a_bias_ctrl: assert property (
        ok && req.wr_en && req.addr == 8'h03 ##1 !req.wr_en |=>
        {ctrl.reference_buffer_enable, ctrl.bias_measure_route,
         ctrl.bias_reference_internal, ctrl.bias_buffer_enable,
         ctrl.bias_sense_enable} ==
        {$past(req.wdata[7], 2), $past(req.wdata[4:1], 2)})
        else $error("bias controls wrong");
    a_route_hit: assert property (
        ok && chan_mux_sel == 3'h2 ##1 ctrl.bias_measure_route
        |-> bias_route_hit)
        else $error("bias route missing");
    a_route_open: assert property (
        ok && chan_mux_sel != 3'h2 |=> !bias_route_hit)
        else $error("bias route closed on wrong mux setting");
    a_dc_level: assert property (
        ok && ctrl.test_dc |-> ctrl.test_pulse)
        else $error("dc level not high");
endmodule // atb_chk
bind atb_config_regs atb_chk u_chk (.mclk(mclk), .resetn(resetn),
    .req(req), .bias_lead_off(bias_lead_off), .chan_mux_sel(chan_mux_sel),
    .rdata(rdata), .ctrl(ctrl), .bias_route_hit(bias_route_hit));

// File: sim/atb_config_regs_tb.sv
`timescale 1ns/100ps
module atb_config_regs_tb;
    import atb_pkg::*;
    logic       mclk = 0, resetn = 0, blo = 0;
    logic [2:0] sel = 0;
    logic [7:0] rdata, sh [2:4], a, d;
    atb_req_s   req;
    atb_ctrl_s  ctrl, c;
    int         error_cnt = 0, compares = 0, cyc = 0, n;
    logic       p;
    logic [15:0] ec;
    atb_host_model host (.mclk(mclk), .req(req));
    atb_config_regs #(.RATE_EXP_SLOW(4), .RATE_EXP_FAST(3)) dut (
        .mclk(mclk), .resetn(resetn), .req(req), .bias_lead_off(blo),
        .chan_mux_sel(sel), .rdata(rdata), .ctrl(ctrl),
        .bias_route_hit());
    initial forever #20 mclk = ~mclk;
    task automatic chk(string s, logic [15:0] e, logic [15:0] g);
        compares++;
        if (g !== e) begin
            $display("CHECK FAILED %s exp %h got %h", s, e, g);
            error_cnt++;
        end
    endtask
    task automatic results();
        if (error_cnt == 0 && compares > 0) $display("RESULT: PASS");
        else $display("RESULT: FAIL");
        $finish;
    endtask
    // Reset, then the documented reset contents
    task automatic rst();
        @(posedge mclk) resetn <= 0;
        blo <= 0;
        repeat (5) @(posedge mclk);
        resetn <= 1;
        repeat (4) @(posedge mclk);
        sh[2] = 8'hC0;
        sh[3] = 8'h60;
        sh[4] = 8'h00;
        for (int i = 2; i < 5; i++) begin
            host.rd(8'(i));
            chk("reset value", sh[i], rdata);
        end
    endtask
    // Hang guard, far above the expected run length
    always @(posedge mclk) begin
        cyc++;
        if (cyc == 6000) begin
            error_cnt++;
            results();
        end
    end
    initial begin
        void'($urandom(78));
        rst();
        repeat (40) begin
            @(posedge mclk) blo <= 1'($urandom);
            sel <= 3'($urandom_range(3, 0));
            a = 8'($urandom_range(5, 1));
            d = 8'($urandom);
            host.wr(a, d);
            if (a == 2) sh[2] = {3'h6, d[4], 1'b0, d[2:0]};
            if (a == 3) sh[3] = {d[7], 2'h3, d[4:1], 1'b0};
            if (a == 4) sh[4] = d & 8'hEF;
            host.rd(a);
            chk("rdata", (a inside {[2:4]}) ? sh[a] | (a == 3 && blo) : 0,
                rdata);
            c = ctrl;
            c.test_pulse = 0;
            // Expected control word, pulse bit masked out
            ec = {sh[2][4], sh[2][2], 1'b0, sh[2][1:0] == 2'h3,
                  sh[3][7], sh[3][4:1], sh[4][7:5], sh[4][3:0]};
            chk("ctrl", ec, c);
        end
        // Pulse rate per code, counted as edges in 64 clocks
        for (int k = 0; k < 4; k++) begin
            host.wr(8'h02, 8'(k));
            repeat (20) @(negedge mclk);
            n = 0;
            for (int i = 0; i < 64; i++) begin
                p = ctrl.test_pulse;
                @(negedge mclk);
                n += int'(ctrl.test_pulse !== p);
            end
            chk("toggles", k == 0 ? 8 : k == 1 ? 16 : 0, 16'(n));
            if (k > 1) chk("level", 16'(k == 3), 16'(ctrl.test_pulse));
        end
        rst();
        results();
    end
endmodule // atb_config_regs_tb
